// File: dv/wsac_conv_model.sv
`timescale 1ns/1ns
module wsac_conv_model (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             fire,
    output logic                  trig_in,
    output wsac_pkg::wsac_sample_t sample_in
);
    import wsac_pkg::*;
    logic [3:0] tick_reg;
    logic [3:0] trig_reg;
    ////////////////////////////////////////////////////////////////
    // New word every 11 cycles; data walks so a stuck capture shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg  <= 4'h0;
            sample_in <= '0;
        end else if (tick_reg == 4'hA) begin
            tick_reg       <= 4'h0;
            sample_in.data <= sample_in.data + 8'h25;
            sample_in.valid <= 1'b1;
        end else begin
            tick_reg        <= tick_reg + 4'h1;
            sample_in.valid <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Shaped trigger held long enough to cross the 2-flop sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_reg <= 4'h0;
        end else if (fire) begin
            trig_reg <= 4'h8;
        end else if (trig_reg != 4'h0) begin
            trig_reg <= trig_reg - 4'h1;
        end
    end
    assign trig_in = (trig_reg != 4'h0);
endmodule

// File: dv/wsac_core_test.sv
`timescale 1ns/1ns
module wsac_core_test;
    import wsac_pkg::*;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          trig_in;
    logic          fire;
    wsac_sample_t  sample_in;
    wsac_readout_t readout;
    logic          sweep_start;
    logic          chan_sel;
    logic          use_store_out;
    logic          store_done;
    logic          sweep_free_run;
    int            errors;
    int            compares;
    int            cyc;
    logic [31:0]   rd;
    logic          er;

    wsac_core wsac_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_in(trig_in), .sample_in(sample_in), .readout(readout), .sweep_start(sweep_start),
        .chan_sel(chan_sel), .use_store_out(use_store_out), .store_done(store_done),
        .sweep_free_run(sweep_free_run));
    wsac_conv_model wsac_conv_model_i (.pclk(pclk), .presetn(presetn), .fire(fire), .trig_in(trig_in),
        .sample_in(sample_in));

    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////
    task results;
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin errors++; results(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task trig;
        @(posedge pclk); fire <= 1'b1;
        @(posedge pclk); fire <= 1'b0;
    endtask

    // Polls one status bit; returns the cycle it was first seen set
    task wait_bit(input int b, input int lim, output int t);
        int n;
        n = 0;
        do begin apb(1'b0, ADDR_STATUS, 32'h0); n++; end
        while (rd[b] !== 1'b1 && n < lim);
        if (n >= lim) begin errors++; results(); end
        t = cyc;
    endtask

    // Waits for the readout strobe at one store address; counts sweep starts on the way
    task rd_at(input logic [9:0] ad, output logic [7:0] d, output int ns);
        int n;
        n = 0;
        ns = 0;
        do begin
            @(posedge pclk);
            if (sweep_start === 1'b1) begin
                ns++;
            end
            n++;
        end
        while (n < 23000 && !(readout.valid === 1'b1 && readout.addr === ad));
        if (n >= 23000) begin errors++; results(); end
        d = readout.data;
    endtask

    // sel 0: next readout strobe, sel 1: next channel change
    task edge_at(input int sel, output int t);
        int n;
        logic last;
        last = chan_sel;
        n = 0;
        do begin @(posedge pclk); n++; end
        while (n < 100 && (sel == 0 ? readout.valid !== 1'b1 : chan_sel === last));
        if (n >= 100) begin errors++; results(); end
        t = cyc;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_regs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, use_store_out}, 32'h0);
        chk({31'h0, sweep_free_run}, 32'h1);
    endtask

    task t_refresh;
        int t0;
        int t1;
        int a;
        apb(1'b1, ADDR_DIV, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1 | (32'h1 << CB_SINGLE) | (32'h1 << CB_ARM));
        idle(2);
        chk({31'h0, use_store_out}, 32'h1);
        edge_at(0, t0);
        edge_at(0, t1);
        chk(t1 - t0, READ_CYC);
        trig;
        t0 = cyc;
        // Trigger needs the sync flops plus one edge before busy shows
        idle(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        wait_bit(0, 4000, t1);
        chk({31'h0, (t1 - t0 >= 1023 * BASE_CYC) && (t1 - t0 <= 1024 * BASE_CYC + 40)}, 32'h1);
        chk(rd[1:0], 2'h1);
        chk({31'h0, store_done}, 32'h1);
        apb(1'b0, ADDR_WADDR, 32'h0);
        a = rd;
        idle(60);
        apb(1'b0, ADDR_WADDR, 32'h0);
        chk(rd, a);
    endtask

    task t_lock;
        int a;
        int ns;
        logic [9:0] ra;
        logic [7:0] d0;
        logic [7:0] d1;
        apb(1'b1, ADDR_DIV, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h2 | (32'h1 << CB_ARM));
        trig;
        idle(40);
        apb(1'b0, ADDR_WADDR, 32'h0);
        a = rd;
        idle(197);
        apb(1'b0, ADDR_WADDR, 32'h0);
        chk({31'h0, ((rd - a) & 32'h3FF) >= 9 && ((rd - a) & 32'h3FF) <= 11}, 32'h1);
        // Write address still steps under lock, so judge the stored word itself
        apb(1'b1, ADDR_CTRL, 32'h2 | (32'h1 << CB_LOCK_FULL));
        edge_at(0, a);
        ra = readout.addr + 10'h002;
        rd_at(ra, d0, ns);
        rd_at(ra, d1, ns);
        chk(d1, d0);
        chk(ns, 1);
    endtask

    task t_dual;
        int t0;
        int t1;
        apb(1'b1, ADDR_DIV, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h2 | (32'h1 << CB_DUAL));
        edge_at(1, t0);
        edge_at(1, t1);
        chk(t1 - t0, BASE_CYC);
    endtask

    task t_roll(input int post);
        int t0;
        int t1;
        int a;
        apb(1'b1, ADDR_CTRL, 32'h2 | (32'h1 << CB_SINGLE) | (post << CB_POST_LO) | (32'h1 << CB_ARM));
        t0 = cyc;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h0);
        wait_bit(2, 4000, t1);
        chk({31'h0, t1 - t0 >= 1023 * BASE_CYC}, 32'h1);
        trig;
        t0 = cyc;
        wait_bit(0, 3000, t1);
        chk({31'h0, (t1 - t0 + BASE_CYC >= post * 256 * BASE_CYC) && (t1 - t0 <= post * 256 * BASE_CYC + 40)}, 32'h1);
        apb(1'b0, ADDR_WADDR, 32'h0);
        a = rd;
        idle(60);
        apb(1'b0, ADDR_WADDR, 32'h0);
        chk(rd, a);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; fire = 1'b0; errors = 0; compares = 0; cyc = 0;
        idle(10);
        presetn <= 1'b1;
        t_regs();
        t_refresh();
        t_lock();
        t_dual();
        for (int p = 0; p < 4; p++) begin
            t_roll(p);
        end
        results();
    end
endmodule

// File: hw/wsac_core.sv
`timescale 1ns/1ns
// Operation
// - 1024-word store of 8-bit samples
// - Full store equals one displayed sweep
// - Continuous non-destructive readout at fixed rate
// - Store display sweeps fixed, synced to readout
// - Refreshed trigger starts read-in, not sweep
// - 91 samples make one cm of trace
// - Range-set programmable divider sets entry rate
// - Divider runs from 1.82 MHz base clock; the code ticks every 10 pclk cycles, 2 MHz
// - Dual channel toggles at entry rate
// - Dual readout alternates channels per sweep
// - Single shot stores one sweep, then stops
// - Lock stops writes immediately
// - Roll mode writes continuously without trigger
// - Roll single shot stops on trigger
// - Post-trigger delay of quarter, half, three quarters
// - Delay and stop only with single shot
// - Refreshed mode routes store output out
// - Normal mode sweep free-runs without trigger
// - Store-complete only after store fully updated
// - Fill whole store before trigger arms
// - Alternate lock preserves second channel locations
module wsac_core
    import wsac_pkg::*;
#(
    parameter int unsigned DEPTH = wsac_pkg::STORE_DEPTH
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [7:0]                       paddr,
    input  wire logic [31:0]                      pwdata,
    output logic [31:0]                           prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             trig_in,
    input  wire wsac_pkg::wsac_sample_t           sample_in,
    output wsac_pkg::wsac_readout_t               readout,
    output logic                                  sweep_start,
    output logic                                  chan_sel,
    output logic                                  use_store_out,
    output logic                                  store_done,
    output logic                                  sweep_free_run
);
    import wsac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [8:0]          ctrl_reg;
    logic [DIV_W-1:0]    div_reg;
    logic                apb_wr;
    logic                apb_rd_ok;
    wsac_mode_t          mode;
    logic                arm_pulse;
    logic [ADDR_W-1:0]   waddr_reg;
    logic                busy_reg;
    logic                armed_reg;
    logic                done_reg;
    logic                trig_seen_reg;

    assign apb_wr    = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign apb_rd_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_DIV) ||
                       (paddr == ADDR_STATUS) || (paddr == ADDR_WADDR);
    assign pslverr   = psel && penable && !apb_rd_ok;
    assign arm_pulse = apb_wr && (paddr == ADDR_CTRL) && pwdata[CB_ARM];

    always_comb begin
        unique case (ctrl_reg[CB_MODE_LO +: 2])
            2'h1:    mode = WSAC_MODE_REFRESHED;
            2'h2:    mode = WSAC_MODE_ROLL;
            default: mode = WSAC_MODE_NORMAL;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 9'h000;
            div_reg  <= 16'h0000;
        end else if (apb_wr) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_reg <= {1'b0, pwdata[7:0]};
            end
            if (paddr == ADDR_DIV) begin
                div_reg <= pwdata[DIV_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_CTRL:   prdata <= {23'h000000, ctrl_reg};
                ADDR_DIV:    prdata <= {16'h0000, div_reg};
                ADDR_STATUS: prdata <= {28'h0000000, trig_seen_reg, armed_reg, busy_reg, done_reg};
                ADDR_WADDR:  prdata <= {22'h000000, waddr_reg};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic          trig_m, trig_s, trig_d;
    wsac_sample_t  smp_m, smp_s;
    logic          trig_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_m <= 1'b0;
            trig_s <= 1'b0;
            trig_d <= 1'b0;
            smp_m  <= '0;
            smp_s  <= '0;
        end else begin
            trig_m <= trig_in;
            trig_s <= trig_m;
            trig_d <= trig_s;
            smp_m  <= sample_in;
            smp_s  <= smp_m;
        end
    end
    assign trig_rise = trig_s && !trig_d;

    ////////////////////////////////////////////////////////////////////////////
    // Entry-rate divider: base tick then range divide
    logic [7:0]          base_cnt;
    logic                base_tick;
    logic [DIV_W-1:0]    ent_cnt;
    logic                entry_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= 8'h00;
        end else if (base_cnt == 8'(BASE_CYC - 1)) begin
            base_cnt <= 8'h00;
        end else begin
            base_cnt <= base_cnt + 8'h01;
        end
    end
    assign base_tick = (base_cnt == 8'(BASE_CYC - 1));

    // Ratio 0 means undivided base, the fastest range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ent_cnt <= 16'h0000;
        end else if (base_tick) begin
            if (ent_cnt >= div_reg) begin
                ent_cnt <= 16'h0000;
            end else begin
                ent_cnt <= ent_cnt + 16'h0001;
            end
        end
    end
    assign entry_tick = base_tick && (ent_cnt >= div_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Store and write control
    logic [SAMPLE_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0]   fill_cnt;
    logic [ADDR_W-1:0]   post_cnt;
    logic [ADDR_W-1:0]   post_lim;
    logic                chan_reg;
    logic                wr_en;
    logic                blocked;
    logic                single;

    assign single  = ctrl_reg[CB_SINGLE];
    // Alternate lock keeps odd (second channel) slots
    assign blocked = ctrl_reg[CB_LOCK_FULL] || (ctrl_reg[CB_LOCK_ALT] && waddr_reg[0]);
    assign wr_en   = entry_tick && busy_reg && !blocked && (mode != WSAC_MODE_NORMAL);

    always_comb begin
        unique case (ctrl_reg[CB_POST_LO +: 2])
            2'h1:    post_lim = ADDR_W'(DEPTH / 4);
            2'h2:    post_lim = ADDR_W'(DEPTH / 2);
            2'h3:    post_lim = ADDR_W'(3 * DEPTH / 4);
            default: post_lim = '0;
        endcase
    end

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[waddr_reg] <= smp_s.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waddr_reg <= '0;
            chan_reg  <= 1'b0;
        end else if (entry_tick && busy_reg) begin
            waddr_reg <= waddr_reg + 1'b1;
            chan_reg  <= ctrl_reg[CB_DUAL] ? ~chan_reg : 1'b0;
        end
    end
    assign chan_sel = chan_reg;

    // Sequence: refreshed waits trigger then fills; roll runs, in single shot stops on trigger after post delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg      <= 1'b0;
            armed_reg     <= 1'b0;
            done_reg      <= 1'b0;
            trig_seen_reg <= 1'b0;
            fill_cnt      <= '0;
            post_cnt      <= '0;
        end else if (arm_pulse || mode == WSAC_MODE_NORMAL) begin
            busy_reg      <= (mode == WSAC_MODE_ROLL);
            armed_reg     <= 1'b0;
            done_reg      <= 1'b0;
            trig_seen_reg <= 1'b0;
            fill_cnt      <= '0;
            post_cnt      <= '0;
        end else if (mode == WSAC_MODE_REFRESHED) begin
            if (!busy_reg && trig_rise && !done_reg) begin
                busy_reg <= 1'b1;
                fill_cnt <= '0;
            end else if (busy_reg && entry_tick) begin
                fill_cnt <= fill_cnt + 1'b1;
                if (fill_cnt == ADDR_W'(DEPTH - 1)) begin
                    busy_reg <= 1'b0;
                    done_reg <= single;
                end
            end
        end else begin
            if (!done_reg) begin
                busy_reg <= 1'b1;
            end
            if (busy_reg && entry_tick && !armed_reg) begin
                fill_cnt <= fill_cnt + 1'b1;
                armed_reg <= (fill_cnt == ADDR_W'(DEPTH - 1));
            end
            if (single && armed_reg && trig_rise && !trig_seen_reg) begin
                trig_seen_reg <= 1'b1;
            end
            if (trig_seen_reg && busy_reg) begin
                if (post_cnt == post_lim) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else if (entry_tick) begin
                    post_cnt <= post_cnt + 1'b1;
                end
            end
        end
    end
    assign store_done = done_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Readout and display sweep
    logic [7:0]          rd_div;
    logic [ADDR_W-1:0]   raddr_reg;
    logic                rsweep_chan;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_div <= 8'h00;
        end else if (rd_div == 8'(READ_CYC - 1)) begin
            rd_div <= 8'h00;
        end else begin
            rd_div <= rd_div + 8'h01;
        end
    end

    // Dual: step by two so one sweep reads one channel's slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raddr_reg   <= '0;
            rsweep_chan <= 1'b0;
            readout     <= '0;
            sweep_start <= 1'b0;
        end else begin
            sweep_start <= 1'b0;
            readout.valid <= 1'b0;
            if (rd_div == 8'(READ_CYC - 1)) begin
                readout.valid <= 1'b1;
                readout.addr  <= raddr_reg;
                readout.data  <= mem[raddr_reg];
                readout.chan  <= rsweep_chan;
                if (ctrl_reg[CB_DUAL]) begin
                    if (raddr_reg >= ADDR_W'(DEPTH - 2)) begin
                        raddr_reg   <= ADDR_W'({rsweep_chan ? 1'b0 : 1'b1});
                        rsweep_chan <= ~rsweep_chan;
                        sweep_start <= 1'b1;
                    end else begin
                        raddr_reg <= raddr_reg + ADDR_W'(2);
                    end
                end else begin
                    raddr_reg <= raddr_reg + 1'b1;
                    if (raddr_reg == ADDR_W'(DEPTH - 1)) begin
                        sweep_start <= 1'b1;
                    end
                end
            end
        end
    end

    assign use_store_out  = (mode != WSAC_MODE_NORMAL);
    assign sweep_free_run = (mode == WSAC_MODE_NORMAL) && !trig_s;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_lock_full;
        @(posedge pclk) disable iff (!presetn)
        ctrl_reg[CB_LOCK_FULL] |-> !wr_en;
    endproperty
    a_lock_full: assert property (p_lock_full) else $error("write while locked");

    property p_alt_lock;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_reg[CB_LOCK_ALT] && waddr_reg[0]) |-> !wr_en;
    endproperty
    a_alt_lock: assert property (p_alt_lock) else $error("second channel overwritten");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (entry_tick && busy_reg) |=> waddr_reg == $past(waddr_reg) + 1'b1;
    endproperty
    a_wrap: assert property (p_wrap) else $error("write address did not step");

    property p_done_idle;
        @(posedge pclk) disable iff (!presetn)
        $rose(done_reg) |-> !busy_reg;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while entry busy");

    property p_normal_no_write;
        @(posedge pclk) disable iff (!presetn)
        (mode == WSAC_MODE_NORMAL) |-> (!wr_en && !use_store_out) ##1 (!busy_reg && !done_reg);
    endproperty
    a_normal_no_write: assert property (p_normal_no_write) else $error("store used in normal mode");

    property p_trig_single;
        @(posedge pclk) disable iff (!presetn)
        $rose(trig_seen_reg) |-> single && armed_reg;
    endproperty
    a_trig_single: assert property (p_trig_single) else $error("stop-on-trigger without single shot");

    property p_chan_toggle;
        @(posedge pclk) disable iff (!presetn)
        (entry_tick && busy_reg && ctrl_reg[CB_DUAL]) |=> chan_reg != $past(chan_reg);
    endproperty
    a_chan_toggle: assert property (p_chan_toggle) else $error("channel did not alternate");

    property p_read_rate;
        @(posedge pclk) disable iff (!presetn)
        readout.valid |=> !readout.valid [*2];
    endproperty
    a_read_rate: assert property (p_read_rate) else $error("readout faster than fixed rate");

    property p_refresh_trig;
        @(posedge pclk) disable iff (!presetn)
        (mode == WSAC_MODE_REFRESHED && !busy_reg && trig_rise && !done_reg && !arm_pulse) |=> busy_reg;
    endproperty
    a_refresh_trig: assert property (p_refresh_trig) else $error("trigger did not start read-in");

endmodule

// File: pkg/wsac_pkg.sv
package wsac_pkg;

    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned STORE_DEPTH     = 1024;
    localparam int unsigned ADDR_W          = 10;
    localparam int unsigned SAMPLE_W        = 8;
    localparam int unsigned SAMPLE_NS       = 550;
    localparam int unsigned BASE_HZ         = 1820000;
    localparam int unsigned SAMPLES_PER_CM  = 91;
    localparam int unsigned READ_HZ         = 910000;
    localparam int unsigned DIV_W           = 16;

    // Base tick: 20 MHz / 1.82 MHz, rounded down so no slower than base
    localparam int unsigned BASE_CYC        = CLK_HZ / BASE_HZ;
    localparam int unsigned READ_CYC        = CLK_HZ / READ_HZ;

    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_DIV        = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_WADDR      = 8'h0C;

    // Control register bit positions
    localparam int unsigned CB_MODE_LO      = 0;
    localparam int unsigned CB_SINGLE       = 2;
    localparam int unsigned CB_LOCK_FULL    = 3;
    localparam int unsigned CB_LOCK_ALT     = 4;
    localparam int unsigned CB_DUAL         = 5;
    localparam int unsigned CB_POST_LO      = 6;
    localparam int unsigned CB_ARM          = 8;

    typedef enum logic [1:0] {
        WSAC_MODE_NORMAL,
        WSAC_MODE_REFRESHED,
        WSAC_MODE_ROLL
    } wsac_mode_t;

    typedef struct packed {
        logic                 valid;
        logic [SAMPLE_W-1:0]  data;
    } wsac_sample_t;

    typedef struct packed {
        logic                 valid;
        logic [ADDR_W-1:0]    addr;
        logic [SAMPLE_W-1:0]  data;
        logic                 chan;
    } wsac_readout_t;

endpackage
